/* File: design/drive_comm_pkg.sv */
// package: register map, field layout and decode types for the drive comm register map
// How it works
// RL1: parameter address is group byte, number byte
// RL2: parameter read covers exactly one parameter
// RL3: command low field: none, stop, run, jog-run
// RL4: bits 4-5: none, forward, reverse, toggle
// RL5: bits 6-7 pick accel/decel set 1-4
// RL6: bits 8-11 pick one of sixteen step speeds
// RL7: bit 12 set ignores bits 6-11
// RL8: bits 13-14 pick operation source; 15 reserved
// RL9: control word: external fault, reset, base block
// RL10: FAULT_CODE returns current fault code
// RL11: status bits 0-1 give run state
// RL12: status bit 2 jog; bits 3-4 direction pair
// RL13: status bit 8 frequency from serial link
// RL14: status bit 9 frequency from analog/terminals
// RL15: status bit 10 run commands from serial
// RL16: status bit 11 parameters locked
// RL17: status bit 12 keypad copy enabled
// RL18: FREQUENCY_COMMAND takes 16-bit frequency command
// RL19: unmapped address answers illegal-data-address exception
package drive_comm_pkg;
   // ==========================================================
   // register addresses
   localparam logic [15:0] ADDR_CMD = 16'h2000;
   localparam logic [15:0] ADDR_FREQ = 16'h2001;
   localparam logic [15:0] ADDR_CTRL = 16'h2002;
   localparam logic [15:0] ADDR_FAULT = 16'h2100;
   localparam logic [15:0] ADDR_STATUS = 16'h2119;
   localparam logic [7:0] PARAM_GROUP_LIMIT = 8'h20;
   // ==========================================================
   // function and exception codes
   localparam logic [7:0] FN_READ_HOLDING = 8'h03;
   localparam logic [7:0] FN_WRITE_SINGLE = 8'h06;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
   localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
   localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
   localparam logic [15:0] ONE_WORD = 16'h0001;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   // ==========================================================
   // command and control word field positions
   localparam int CMD_RUN_LSB = 0;
   localparam int CMD_DIR_LSB = 4;
   localparam int CMD_ACC_LSB = 6;
   localparam int CMD_STEP_LSB = 8;
   localparam int CMD_HOLD_BIT = 12;
   localparam int CMD_SRC_LSB = 13;
   localparam int CTRL_EF_BIT = 0;
   localparam int CTRL_RESET_BIT = 1;
   localparam int CTRL_BB_BIT = 2;
   // ==========================================================
   // decoded command values
   typedef enum logic [1:0] {RUN_NONE, RUN_STOP, RUN_GO, RUN_JOG_GO} run_cmd_type;
   typedef enum logic [1:0] {DIR_NONE, DIR_FORWARD, DIR_REVERSE, DIR_TOGGLE} dir_cmd_type;
   typedef enum logic [1:0] {SRC_NONE, SRC_KEYPAD, SRC_PARAM, SRC_SWITCH} src_cmd_type;
   // decoded command carrier
   typedef struct packed {
      run_cmd_type run;
      dir_cmd_type dir;
      logic [1:0] accel_set;
      logic [3:0] step_speed;
      src_cmd_type source;
   } drive_cmd_type;
   // drive state fed back into the status word
   typedef struct packed {
      logic [1:0] run_state;
      logic jog_active;
      logic [1:0] dir_pair;
      logic freq_from_comm;
      logic freq_from_analog;
      logic run_from_comm;
      logic params_locked;
      logic copy_enabled;
   } drive_state_type;
   // request from the frame engine
   typedef struct packed {
      logic valid;
      logic [7:0] func;
      logic [15:0] addr;
      logic [15:0] data;
   } comm_req_type;
   // answer to the frame engine
   typedef struct packed {
      logic valid;
      logic [7:0] exc;
      logic [15:0] data;
      logic param_read;
      logic param_write;
      logic [7:0] group;
      logic [7:0] number;
   } comm_rsp_type;
endpackage

/* File: design/drive_comm_register_map.sv */
// register map behind the drive serial slave: command, frequency, control, fault, status
`timescale 1ns/10ps
module drive_comm_register_map (
   input wire logic clk_sys_i, // 50 MHz controller clock
   input wire logic rstn_i, // synchronous reset, active low
   input wire drive_comm_pkg::comm_req_type req_i, // decoded request, one-cycle valid
   input wire drive_comm_pkg::drive_state_type state_i, // live drive state
   input wire logic [15:0] fault_code_i, // current fault code
   output drive_comm_pkg::comm_rsp_type rsp_o, // answer, one cycle after request
   output drive_comm_pkg::drive_cmd_type cmd_o, // held decoded command
   output logic cmd_strobe_o, // pulse: command word written
   output logic [15:0] freq_cmd_o, // commanded output frequency
   output logic freq_strobe_o, // pulse: frequency written
   output logic ext_fault_o, // pulse: external fault asserted
   output logic fault_reset_o, // pulse: fault reset request
   output logic base_block_o // pulse: force base block
);
   // ==========================================================
   // request classification
   logic is_read; // read-holding function
   logic is_write; // write-single function
   logic is_param; // address in parameter space
   logic [15:0] status_word; // assembled status
   drive_comm_pkg::drive_cmd_type decoded; // decode of the written word

   // function code alone tells reads from writes; the word count is judged later
   assign is_read = req_i.func == drive_comm_pkg::FN_READ_HOLDING;
   assign is_write = req_i.func == drive_comm_pkg::FN_WRITE_SINGLE;
   // group byte below the special range marks a parameter address
   assign is_param = req_i.addr[15:8] < drive_comm_pkg::PARAM_GROUP_LIMIT; // RL1

   // ==========================================================
   // status word assembly; reserved bits 5-7 and 13-15 read zero
   always_comb begin
      // start from zero so reserved bits can never leak a stale value
      status_word = drive_comm_pkg::ZERO_WORD;
      status_word[1:0] = state_i.run_state; // RL11
      status_word[2] = state_i.jog_active; // RL12
      status_word[4:3] = state_i.dir_pair; // RL12
      status_word[8] = state_i.freq_from_comm; // RL13
      status_word[9] = state_i.freq_from_analog; // RL14
      status_word[10] = state_i.run_from_comm; // RL15
      status_word[11] = state_i.params_locked; // RL16
      status_word[12] = state_i.copy_enabled; // RL17
   end

   // ==========================================================
   // command word decode, holding old selections when bit 12 set
   always_comb begin
      // run, direction and source are always taken from the written word
      decoded.run = drive_comm_pkg::run_cmd_type'(req_i.data[drive_comm_pkg::CMD_RUN_LSB +: 2]); // RL3
      decoded.dir = drive_comm_pkg::dir_cmd_type'(req_i.data[drive_comm_pkg::CMD_DIR_LSB +: 2]); // RL4
      decoded.source = drive_comm_pkg::src_cmd_type'(req_i.data[drive_comm_pkg::CMD_SRC_LSB +: 2]); // RL8
      // hold bit set: acceleration set and step speed stay as they were
      if (req_i.data[drive_comm_pkg::CMD_HOLD_BIT]) begin
         // keep previous selections so a plain run/stop cannot disturb them
         decoded.accel_set = cmd_o.accel_set; // RL7
         decoded.step_speed = cmd_o.step_speed; // RL7
      end else begin
         decoded.accel_set = req_i.data[drive_comm_pkg::CMD_ACC_LSB +: 2]; // RL5
         decoded.step_speed = req_i.data[drive_comm_pkg::CMD_STEP_LSB +: 4]; // RL6
      end
   end

   // ==========================================================
   // next-state computation for all registers
   drive_comm_pkg::comm_rsp_type next_rsp;
   drive_comm_pkg::drive_cmd_type next_cmd;
   logic next_cmd_strobe;
   logic [15:0] next_freq;
   logic next_freq_strobe;
   logic next_ef;
   logic next_reset;
   logic next_bb;
   // one process decides the answer and every register's next value;
   // pulses default low so each one lasts exactly a single cycle,
   // and levels default to their own held value

   always_comb begin
      next_rsp = '0;
      next_cmd = cmd_o;
      next_cmd_strobe = 1'b0;
      next_freq = freq_cmd_o;
      next_freq_strobe = 1'b0;
      next_ef = 1'b0;
      next_reset = 1'b0;
      next_bb = 1'b0;
      // nothing moves without a request; the answer always follows one cycle later
      if (req_i.valid) begin
         next_rsp.valid = 1'b1;
         next_rsp.exc = drive_comm_pkg::EXC_NONE;
         // only the two single-word functions are served
         if (!is_read && !is_write) begin
            next_rsp.exc = drive_comm_pkg::EXC_ILLEGAL_FUNCTION;
         end else if (is_param) begin
            // parameter store lives outside; hand on group and number
            next_rsp.group = req_i.addr[15:8]; // RL1
            next_rsp.number = req_i.addr[7:0]; // RL1
            // a parameter read must name exactly one word
            if (is_read && req_i.data != drive_comm_pkg::ONE_WORD) begin
               next_rsp.exc = drive_comm_pkg::EXC_ILLEGAL_VALUE; // RL2
            end else begin
               next_rsp.param_read = is_read;
               next_rsp.param_write = is_write;
            end
         end else if (is_write) begin
            // writes decode the full address; a near miss is refused
            unique case (req_i.addr)
               // command word: the decode has already applied the hold bit
               drive_comm_pkg::ADDR_CMD: begin
                  next_cmd = decoded;
                  next_cmd_strobe = 1'b1;
               end
               // frequency word is taken whole; no range check is made here
               drive_comm_pkg::ADDR_FREQ: begin
                  next_freq = req_i.data; // RL18
                  next_freq_strobe = 1'b1;
               end
               // control word: each bit becomes a one-cycle pulse, bits 3-15 dropped
               drive_comm_pkg::ADDR_CTRL: begin
                  next_ef = req_i.data[drive_comm_pkg::CTRL_EF_BIT]; // RL9
                  next_reset = req_i.data[drive_comm_pkg::CTRL_RESET_BIT]; // RL9
                  next_bb = req_i.data[drive_comm_pkg::CTRL_BB_BIT]; // RL9
               end
               // any other word in the special range has no writable register
               default: begin
                  next_rsp.exc = drive_comm_pkg::EXC_ILLEGAL_ADDRESS; // RL19
               end
            endcase
         end else begin
            // one-word reads only; write-only words are not readable
            if (req_i.data != drive_comm_pkg::ONE_WORD) begin
               next_rsp.exc = drive_comm_pkg::EXC_ILLEGAL_VALUE;
            end else if (req_i.addr == drive_comm_pkg::ADDR_FAULT) begin
               next_rsp.data = fault_code_i; // RL10
            end else if (req_i.addr == drive_comm_pkg::ADDR_STATUS) begin
               next_rsp.data = status_word; // RL11
            end else begin
               next_rsp.exc = drive_comm_pkg::EXC_ILLEGAL_ADDRESS; // RL19
            end
         end
      end
   end

   // ==========================================================
   // registers; commands default to no action after reset
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         // command returns to no action so a stray run cannot outlive a reset
         rsp_o <= '0;
         cmd_o <= '0;
         cmd_strobe_o <= 1'b0;
         freq_cmd_o <= drive_comm_pkg::ZERO_WORD;
         freq_strobe_o <= 1'b0;
         ext_fault_o <= 1'b0;
         fault_reset_o <= 1'b0;
         base_block_o <= 1'b0;
      end else begin
         rsp_o <= next_rsp;
         cmd_o <= next_cmd;
         cmd_strobe_o <= next_cmd_strobe;
         freq_cmd_o <= next_freq;
         freq_strobe_o <= next_freq_strobe;
         ext_fault_o <= next_ef;
         fault_reset_o <= next_reset;
         base_block_o <= next_bb;
      end
   end

   // ==========================================================
   // checks
   a_unmapped_write_exc: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_write && !is_param && req_i.addr != drive_comm_pkg::ADDR_CMD
      && req_i.addr != drive_comm_pkg::ADDR_FREQ && req_i.addr != drive_comm_pkg::ADDR_CTRL
      |=> rsp_o.exc == drive_comm_pkg::EXC_ILLEGAL_ADDRESS) // RL19
      else $error("unmapped write not refused");
   a_param_multi_read: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_read && is_param && req_i.data != drive_comm_pkg::ONE_WORD
      |=> rsp_o.exc != drive_comm_pkg::EXC_NONE && !rsp_o.param_read) // RL2
      else $error("multi-parameter read accepted");
   a_param_addr_split: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_param && (is_read || is_write)
      |=> {rsp_o.group, rsp_o.number} == $past(req_i.addr)) // RL1
      else $error("parameter address split wrong");
   a_fault_read_data: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_read && req_i.addr == drive_comm_pkg::ADDR_FAULT
      && req_i.data == drive_comm_pkg::ONE_WORD |=> rsp_o.data == $past(fault_code_i)) // RL10
      else $error("fault code read wrong");
   a_status_fields: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_read && req_i.addr == drive_comm_pkg::ADDR_STATUS
      && req_i.data == drive_comm_pkg::ONE_WORD
      |=> rsp_o.data[1:0] == $past(state_i.run_state) && rsp_o.data[7:5] == 3'h0
      && rsp_o.data[12:8] == $past({state_i.copy_enabled, state_i.params_locked,
      state_i.run_from_comm, state_i.freq_from_analog, state_i.freq_from_comm})) // RL11
      else $error("status word fields wrong");
   a_status_jog_dir: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      rsp_o.valid && rsp_o.exc == drive_comm_pkg::EXC_NONE
      && $past(req_i.addr) == drive_comm_pkg::ADDR_STATUS && $past(is_read)
      |-> rsp_o.data[4:2] == $past({state_i.dir_pair, state_i.jog_active})) // RL12
      else $error("status jog or direction wrong");
   a_hold_keeps_sel: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_write && req_i.addr == drive_comm_pkg::ADDR_CMD
      && req_i.data[drive_comm_pkg::CMD_HOLD_BIT]
      |=> $stable({cmd_o.accel_set, cmd_o.step_speed})) // RL7
      else $error("held selections changed");
   a_cmd_decode: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_write && req_i.addr == drive_comm_pkg::ADDR_CMD
      && !req_i.data[drive_comm_pkg::CMD_HOLD_BIT]
      |=> cmd_strobe_o && cmd_o.step_speed == $past(req_i.data[11:8])
      && cmd_o.accel_set == $past(req_i.data[7:6]) && cmd_o.dir == $past(req_i.data[5:4])
      && cmd_o.run == $past(req_i.data[1:0]) && cmd_o.source == $past(req_i.data[14:13])) // RL3
      else $error("command decode wrong");
   a_ctrl_pulses: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_write && req_i.addr == drive_comm_pkg::ADDR_CTRL
      |=> {base_block_o, fault_reset_o, ext_fault_o} == $past(req_i.data[2:0])
      ##1 !ext_fault_o || $past(req_i.valid)) // RL9
      else $error("control pulses wrong");
   a_freq_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_write && req_i.addr == drive_comm_pkg::ADDR_FREQ
      |=> freq_strobe_o && freq_cmd_o == $past(req_i.data)) // RL18
      else $error("frequency write lost");

   // ==========================================================
   // further checks; each watches one answer path so that a failure
   // names the path at fault rather than a whole transfer
   // idle cycles must leave every pulse low
   a_idle_no_pulse: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      !req_i.valid
      |=> !rsp_o.valid && !cmd_strobe_o && !freq_strobe_o
      && !ext_fault_o && !fault_reset_o && !base_block_o) // RL9
      else $error("pulse without request");

   // every request is answered on the next edge
   a_answer_timing: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid |=> rsp_o.valid) // RL19
      else $error("request not answered");

   // an unknown function must raise no command or frequency strobe and no parameter write
   a_bad_func_exc: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && !is_read && !is_write
      |=> rsp_o.exc == drive_comm_pkg::EXC_ILLEGAL_FUNCTION
      && !cmd_strobe_o && !freq_strobe_o && !rsp_o.param_write) // RL19
      else $error("unknown function not refused");

   // write-only words are refused when read
   a_wo_read_exc: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_read && req_i.data == drive_comm_pkg::ONE_WORD
      && (req_i.addr == drive_comm_pkg::ADDR_CMD || req_i.addr == drive_comm_pkg::ADDR_FREQ
      || req_i.addr == drive_comm_pkg::ADDR_CTRL)
      |=> rsp_o.exc == drive_comm_pkg::EXC_ILLEGAL_ADDRESS
      && rsp_o.data == drive_comm_pkg::ZERO_WORD) // RL19
      else $error("write-only word readable");

   // reserved upper status bits read as zero
   a_status_top_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_read && req_i.addr == drive_comm_pkg::ADDR_STATUS
      && req_i.data == drive_comm_pkg::ONE_WORD
      |=> rsp_o.data[15:13] == 3'h0) // RL17
      else $error("reserved status bits set");

   // frequency level moves only on its own write
   a_freq_steady: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      !(req_i.valid && is_write && req_i.addr == drive_comm_pkg::ADDR_FREQ)
      |=> $stable(freq_cmd_o) && !freq_strobe_o) // RL18
      else $error("frequency changed without write");

   // command level moves only on its own write
   a_cmd_steady: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      !(req_i.valid && is_write && req_i.addr == drive_comm_pkg::ADDR_CMD)
      |=> $stable(cmd_o) && !cmd_strobe_o) // RL3
      else $error("command changed without write");

   // a held write still takes run, direction and source
   a_hold_takes_run: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_write && req_i.addr == drive_comm_pkg::ADDR_CMD
      && req_i.data[drive_comm_pkg::CMD_HOLD_BIT]
      |=> cmd_strobe_o && cmd_o.run == $past(req_i.data[1:0])
      && cmd_o.dir == $past(req_i.data[5:4])
      && cmd_o.source == $past(req_i.data[14:13])) // RL7
      else $error("held write lost run or source");

   // a control write with the three low bits clear raises nothing
   a_ctrl_quiet: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_write && req_i.addr == drive_comm_pkg::ADDR_CTRL
      && req_i.data[2:0] == 3'h0
      |=> !ext_fault_o && !fault_reset_o && !base_block_o) // RL9
      else $error("unused control bits acted");

   // a parameter write passes through untouched by the map
   a_param_write_pass: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_write && is_param
      |=> rsp_o.param_write && rsp_o.exc == drive_comm_pkg::EXC_NONE
      && !cmd_strobe_o && !freq_strobe_o) // RL1
      else $error("parameter write not passed on");

   // a single-word parameter read is handed on
   a_param_one_read: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      req_i.valid && is_read && is_param && req_i.data == drive_comm_pkg::ONE_WORD
      |=> rsp_o.param_read && rsp_o.exc == drive_comm_pkg::EXC_NONE) // RL2
      else $error("single parameter read refused");
endmodule

/* File: tb/modbus_master_model.sv */
// master model: issues single-word requests toward the register map
`timescale 1ns/10ps
module modbus_master_model (
   input wire logic clk_sys_i, // system clock
   output drive_comm_pkg::comm_req_type req_o // request toward the map
);
   // ==========================================
   // request issue
   initial begin
      req_o = '0;
   end
   // gap idles before the request; the bench always passes a gap of one, so only prompt masters appear
   task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
      input int gap);
      repeat (gap) @(posedge clk_sys_i);
      #1;
      // a read carries a word count; one parameter read sends two so that it is refused
      req_o = '{valid: 1'b1, func: f, addr: a, data: d};
      @(posedge clk_sys_i);
      #1;
      // released fields show inverted junk so stale values never look valid
      req_o = '{valid: 1'b0, func: ~f, addr: ~a, data: ~d};
   endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the drive comm register map
`timescale 1ns/10ps
module tb_top;
   // ==========================================
   // stimulus and observed signals
   logic clk_sys_i = 1'b0; // 50 MHz clock
   logic rstn_i = 1'b0; // reset, active low
   drive_comm_pkg::comm_req_type req; // from master model
   drive_comm_pkg::drive_state_type st = '0; // live drive state
   logic [15:0] fcode = 16'h0000; // current fault code
   drive_comm_pkg::comm_rsp_type rsp; // answer
   drive_comm_pkg::drive_cmd_type cmd; // decoded command
   logic cmd_stb, freq_stb, ef, frst, bb; // pulses
   logic [15:0] freq; // frequency level
   int err_total = 0; // mismatches
   int compares = 0; // comparisons made
   int cycles = 0; // timeout counter
   always #10 clk_sys_i = ~clk_sys_i;
   modbus_master_model modbus_master_model_i (.clk_sys_i(clk_sys_i), .req_o(req));
   drive_comm_register_map drive_comm_register_map_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .req_i(req), .state_i(st), .fault_code_i(fcode), .rsp_o(rsp), .cmd_o(cmd),
      .cmd_strobe_o(cmd_stb), .freq_cmd_o(freq), .freq_strobe_o(freq_stb), .ext_fault_o(ef),
      .fault_reset_o(frst), .base_block_o(bb));
   // ==========================================
   // checking helpers
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // one request, answer judged in the cycle it stands
   task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
      input logic [7:0] ex, input logic [15:0] rd);
      modbus_master_model_i.send(f, a, d, 1);
      chk("rsp_valid", 16'h0001, 16'(rsp.valid));
      chk("rsp_exc", 16'(ex), 16'(rsp.exc));
      chk("rsp_data", rd, rsp.data);
   endtask
   task automatic print_verdict();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // cut a hang short; the whole run needs well under a thousand cycles
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         print_verdict();
      end
   end
   // ==========================================
   // scenarios
   task automatic t_cmd();
      logic [15:0] w;
      for (int i = 0; i < 4; i++) begin
         w = {1'b1, 2'(i), 1'b0, 4'(i * 5), 2'(i), 2'(i), 2'b00, 2'(i)};
         xfer(8'h06, drive_comm_pkg::ADDR_CMD, w, 8'h00, 16'h0000);
         chk("cmd_stb", 16'h0001, 16'(cmd_stb));
         chk("run", 16'(i), 16'(cmd.run));
         chk("dir", 16'(i), 16'(cmd.dir));
         chk("accel", 16'(i), 16'(cmd.accel_set));
         chk("step", 16'(i * 5), 16'(cmd.step_speed));
         chk("src", 16'(i), 16'(cmd.source));
      end
      // hold bit set: accel and step keep 3 and 15 from the last write
      xfer(8'h06, drive_comm_pkg::ADDR_CMD, 16'h3D51, 8'h00, 16'h0000);
      chk("hold_run", 16'h0001, 16'(cmd.run));
      chk("hold_acc", 16'h0003, 16'(cmd.accel_set));
      chk("hold_step", 16'h000F, 16'(cmd.step_speed));
      chk("hold_src", 16'h0001, 16'(cmd.source));
   endtask
   task automatic t_freq();
      xfer(8'h06, drive_comm_pkg::ADDR_FREQ, 16'hA55A, 8'h00, 16'h0000);
      chk("freq_stb", 16'h0001, 16'(freq_stb));
      @(posedge clk_sys_i);
      #1;
      chk("freq_stb_end", 16'h0000, 16'(freq_stb));
      chk("freq", 16'hA55A, freq);
   endtask
   task automatic t_ctrl();
      for (int b = 0; b < 4; b++) begin
         // b of 3 writes only the unused bits 3..15
         xfer(8'h06, drive_comm_pkg::ADDR_CTRL, (b < 3) ? 16'(1 << b) : 16'hFFF8, 8'h00, 16'h0000);
         chk("ext_fault", 16'(b == 0), 16'(ef));
         chk("fault_reset", 16'(b == 1), 16'(frst));
         chk("base_block", 16'(b == 2), 16'(bb));
      end
   endtask
   task automatic t_read();
      fcode = 16'hBEEF;
      xfer(8'h03, drive_comm_pkg::ADDR_FAULT, 16'h0001, 8'h00, 16'hBEEF);
      for (int i = 0; i < 4; i++) begin
         st = '{run_state: 2'(i), jog_active: i[0], dir_pair: 2'(i % 3), freq_from_comm: i[0],
            freq_from_analog: ~i[0], run_from_comm: i[1], params_locked: ~i[1],
            copy_enabled: i[0]};
         xfer(8'h03, drive_comm_pkg::ADDR_STATUS, 16'h0001, 8'h00, {3'b000, st.copy_enabled,
            st.params_locked, st.run_from_comm, st.freq_from_analog, st.freq_from_comm, 3'b000,
            st.dir_pair, st.jog_active, st.run_state});
      end
   endtask
   task automatic t_param();
      xfer(8'h03, 16'h0401, 16'h0001, 8'h00, 16'h0000);
      chk("param_read", 16'h0001, 16'(rsp.param_read));
      chk("group", 16'h0004, 16'(rsp.group));
      chk("number", 16'h0001, 16'(rsp.number));
      xfer(8'h03, 16'h1FFF, 16'h0002, 8'h03, 16'h0000);
      xfer(8'h06, 16'h1F05, 16'h1234, 8'h00, 16'h0000);
      chk("param_write", 16'h0001, 16'(rsp.param_write));
      chk("group_w", 16'h001F, 16'(rsp.group));
      chk("number_w", 16'h0005, 16'(rsp.number));
   endtask
   task automatic t_bad();
      xfer(8'h03, drive_comm_pkg::ADDR_FREQ, 16'h0001, 8'h02, 16'h0000);
      xfer(8'h06, drive_comm_pkg::ADDR_FAULT, 16'h1234, 8'h02, 16'h0000);
      xfer(8'h03, 16'h2005, 16'h0001, 8'h02, 16'h0000);
      xfer(8'h10, drive_comm_pkg::ADDR_FREQ, 16'h1234, 8'h01, 16'h0000);
      chk("freq_keep", 16'hA55A, freq);
      chk("freq_stb_none", 16'h0000, 16'(freq_stb));
   endtask
   // reset in mid-run: levels clear and the next request is served at once
   task automatic t_reset();
      @(posedge clk_sys_i);
      #1;
      rstn_i = 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk("cmd_rst", 16'h0000, 16'(cmd));
      chk("freq_rst", 16'h0000, freq);
      chk("rsp_rst", 16'h0000, 16'(rsp.valid));
      rstn_i = 1'b1;
      xfer(8'h06, drive_comm_pkg::ADDR_FREQ, 16'h5AA5, 8'h00, 16'h0000);
      chk("freq_after_rst", 16'h5AA5, freq);
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (16) @(posedge clk_sys_i);
      #1;
      chk("rsp_idle", 16'h0000, 16'(rsp.valid));
      chk("freq_reset", 16'h0000, freq);
      rstn_i = 1'b1;
      t_cmd();
      t_freq();
      t_ctrl();
      t_read();
      t_param();
      t_bad();
      t_reset();
      print_verdict();
   end
endmodule
